//--- hw/eeac_top.sv
// Two-wire slave giving access to the byte memory with page programming
// Behaviour
// - Acknowledge address, command, location, data bytes
// - Over eight bytes wrap, keep last eight
// - Programming starts only at closing STOP
// - START instead of STOP discards write
// - Programming lasts 10 ms typical
// - Withhold command acknowledge while programming
// - Each sent byte advances location by one
`include "eeac_params.svh"
module eeac_top #(
  parameter logic [6:0] DEV_ADDR = `EEAC_DEV_ADDR,
  parameter int unsigned PROG_CYCLES = `EEAC_TWR_MS * (`EEAC_CLK_HZ / 1000)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_busy
);
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  eeac_pkg::eeac_bus_e st_reg;
  eeac_pkg::eeac_pg_e pg_reg;
  logic [3:0] bit_reg;
  logic ack_reg, acked_reg, tx_reg, mnack_reg, wany_reg, prog_req_reg;
  logic [7:0] shift_reg, ptr_reg, rdata;
  logic [2:0] wcnt_reg, cidx_reg;
  logic [4:0] page_hi_reg;
  logic [7:0] page_valid_reg;
  logic [7:0] page_data_reg [`EEAC_PAGE_BYTES];
  logic [31:0] tmr_reg;
  eeac_pkg::eeac_wbyte_s fifo_reg [2];
  logic fifo_wp_reg, fifo_rp_reg;
  logic [1:0] fifo_cnt_reg;
  logic start_ev, stop_ev, rise, fall, active, ack_start, ack_end, ack_ok;
  logic load_tx, wr_push, loc_set, abort, busy, fifo_ready, fifo_pop;
  eeac_pkg::eeac_wbyte_s push_w;

  // Two flops on each pin; the third stage only feeds edge detection
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {scl_m, scl_s, scl_q} <= 3'h7;
      {sda_m, sda_s, sda_q} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_q} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {i_sda, sda_m, sda_s};
    end
  end

  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = scl_s && scl_q && !sda_q && sda_s;
  assign rise = scl_s && !scl_q;
  assign fall = !scl_s && scl_q;
  assign active = !start_ev && !stop_ev && (st_reg != eeac_pkg::ST_IDLE);
  assign ack_start = active && fall && !ack_reg && (bit_reg == `EEAC_ACK_SLOT);
  assign ack_end = active && fall && ack_reg;
  assign busy = prog_req_reg || (pg_reg != eeac_pkg::PG_IDLE);
  assign fifo_ready = (fifo_cnt_reg != 2'h2);
  assign fifo_pop = (fifo_cnt_reg != 2'h0) && (pg_reg == eeac_pkg::PG_IDLE);
  assign abort = start_ev && (st_reg == eeac_pkg::ST_WDATA);
  assign load_tx = ack_end && ((tx_reg && !mnack_reg) ||
                   (!tx_reg && st_reg == eeac_pkg::ST_ADDR && acked_reg && shift_reg[0]));
  assign wr_push = ack_start && (st_reg == eeac_pkg::ST_WDATA) && fifo_ready;
  assign loc_set = ack_end && (st_reg == eeac_pkg::ST_LOC);
  assign push_w.idx = ptr_reg[2:0] + wcnt_reg;
  assign push_w.data = shift_reg;

  always_comb begin
    ack_ok = 1'b0;
    unique case (st_reg)
      eeac_pkg::ST_ADDR: ack_ok = (shift_reg[7:1] == DEV_ADDR);
      eeac_pkg::ST_CMD: ack_ok = (shift_reg == `EEAC_CMD_MEM) && !busy;
      eeac_pkg::ST_LOC: ack_ok = 1'b1;
      eeac_pkg::ST_WDATA: ack_ok = fifo_ready;
      eeac_pkg::ST_IDLE: ack_ok = 1'b0;
      eeac_pkg::ST_RDATA: ack_ok = 1'b0;
    endcase
  end

  // Byte engine: bits taken on SCL rise, SDA changed on SCL fall
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_reg <= eeac_pkg::ST_IDLE;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      acked_reg <= 1'b0;
      tx_reg <= 1'b0;
      mnack_reg <= 1'b0;
      shift_reg <= 8'h00;
      o_sda_oe <= 1'b0;
    end else if (start_ev) begin
      st_reg <= eeac_pkg::ST_ADDR;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      tx_reg <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= eeac_pkg::ST_IDLE;
      ack_reg <= 1'b0;
      tx_reg <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (st_reg != eeac_pkg::ST_IDLE) begin
      if (rise) begin
        if (!ack_reg) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_reg <= bit_reg + 4'h1;
        end else if (tx_reg) begin
          mnack_reg <= sda_s;
        end
      end
      if (ack_start) begin
        ack_reg <= 1'b1;
        acked_reg <= ack_ok;
        o_sda_oe <= !tx_reg && ack_ok;
      end else if (ack_end) begin
        ack_reg <= 1'b0;
        bit_reg <= 4'h0;
        o_sda_oe <= 1'b0;
        if (load_tx) begin
          st_reg <= eeac_pkg::ST_RDATA;
          tx_reg <= 1'b1;
          shift_reg <= rdata;
          o_sda_oe <= !rdata[7];
        end else if (tx_reg || !acked_reg) begin
          // Refused or finished: ignore the bus until the next START
          st_reg <= eeac_pkg::ST_IDLE;
          tx_reg <= 1'b0;
        end else if (st_reg == eeac_pkg::ST_ADDR) begin
          st_reg <= eeac_pkg::ST_CMD;
        end else if (st_reg == eeac_pkg::ST_CMD) begin
          st_reg <= eeac_pkg::ST_LOC;
        end else if (st_reg == eeac_pkg::ST_LOC) begin
          st_reg <= eeac_pkg::ST_WDATA;
        end
      end else if (fall && tx_reg && !ack_reg) begin
        o_sda_oe <= !shift_reg[7];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ptr_reg <= 8'h00;
    end else if (loc_set) begin
      ptr_reg <= shift_reg;
    end else if (load_tx) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Write count wraps at eight, so the page slot repeats after eight bytes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wcnt_reg <= 3'h0;
      wany_reg <= 1'b0;
    end else if (loc_set || start_ev) begin
      wcnt_reg <= 3'h0;
      wany_reg <= 1'b0;
    end else if (wr_push) begin
      wcnt_reg <= wcnt_reg + 3'h1;
      wany_reg <= 1'b1;
    end
  end

  // Two-entry buffer from the byte engine to the page buffer
  always_ff @(posedge i_clk) begin
    if (i_reset || abort) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (wr_push) begin
        fifo_reg[fifo_wp_reg] <= push_w;
        fifo_wp_reg <= !fifo_wp_reg;
      end
      if (fifo_pop) begin
        fifo_rp_reg <= !fifo_rp_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, wr_push} - {1'b0, fifo_pop};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || abort) begin
      page_valid_reg <= 8'h00;
    end else if (loc_set) begin
      page_valid_reg <= 8'h00;
    end else if (pg_reg == eeac_pkg::PG_COPY && cidx_reg == 3'h7) begin
      page_valid_reg <= 8'h00;
    end else if (fifo_pop) begin
      page_valid_reg[fifo_reg[fifo_rp_reg].idx] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (loc_set) begin
      page_hi_reg <= shift_reg[7:3];
    end
    if (fifo_pop) begin
      page_data_reg[fifo_reg[fifo_rp_reg].idx] <= fifo_reg[fifo_rp_reg].data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || abort) begin
      prog_req_reg <= 1'b0;
    end else if (stop_ev && st_reg == eeac_pkg::ST_WDATA && wany_reg) begin
      prog_req_reg <= 1'b1;
    end else if (pg_reg == eeac_pkg::PG_COPY) begin
      prog_req_reg <= 1'b0;
    end
  end

  // Programming: copy the kept slots, then hold busy for the write time
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pg_reg <= eeac_pkg::PG_IDLE;
      cidx_reg <= 3'h0;
      tmr_reg <= 32'h0;
    end else begin
      unique case (pg_reg)
        eeac_pkg::PG_IDLE: begin
          if (prog_req_reg && fifo_cnt_reg == 2'h0) begin
            pg_reg <= eeac_pkg::PG_COPY;
            cidx_reg <= 3'h0;
          end
        end
        eeac_pkg::PG_COPY: begin
          cidx_reg <= cidx_reg + 3'h1;
          if (cidx_reg == 3'h7) begin
            pg_reg <= eeac_pkg::PG_WAIT;
            tmr_reg <= 32'(PROG_CYCLES - 1);
          end
        end
        eeac_pkg::PG_WAIT: begin
          tmr_reg <= tmr_reg - 32'h1;
          if (tmr_reg == 32'h0) begin
            pg_reg <= eeac_pkg::PG_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_busy <= busy;
      o_sda_out <= 1'b0;
    end
  end

  eeac_mem #(.DEPTH(`EEAC_MEM_DEPTH), .AW(8)) u_mem (
    .i_clk(i_clk),
    .i_we(pg_reg == eeac_pkg::PG_COPY && page_valid_reg[cidx_reg]),
    .i_waddr({page_hi_reg, cidx_reg}),
    .i_wdata(page_data_reg[cidx_reg]),
    .i_raddr(ptr_reg),
    .o_rdata(rdata)
  );

  property p_ack_loc;
    @(posedge i_clk) disable iff (i_reset)
    (ack_start && st_reg == eeac_pkg::ST_LOC) |=> o_sda_oe ##1 o_sda_oe;
  endproperty
  a_ack_loc: assert property (p_ack_loc) else $error("location byte not acked");
  // A popped byte must mark its page slot, so repeated slots stay kept
  property p_wrap;
    @(posedge i_clk) disable iff (i_reset)
    (fifo_pop && !abort) |=> page_valid_reg[$past(fifo_reg[fifo_rp_reg].idx)];
  endproperty
  a_wrap: assert property (p_wrap) else $error("write slot not wrapped");
  property p_prog_on_stop;
    @(posedge i_clk) disable iff (i_reset)
    $rose(prog_req_reg) |-> $past(stop_ev) && $past(st_reg) == eeac_pkg::ST_WDATA;
  endproperty
  a_prog_on_stop: assert property (p_prog_on_stop) else $error("program without stop");
  property p_abort;
    @(posedge i_clk) disable iff (i_reset)
    abort |=> !prog_req_reg && page_valid_reg == 8'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("write kept after start");
  property p_prog_time;
    @(posedge i_clk) disable iff (i_reset)
    (pg_reg == eeac_pkg::PG_COPY ##1 pg_reg == eeac_pkg::PG_WAIT)
      |-> tmr_reg == 32'(PROG_CYCLES - 1);
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("wrong write time");
  property p_busy_nack;
    @(posedge i_clk) disable iff (i_reset)
    (ack_start && st_reg == eeac_pkg::ST_CMD && busy) |=> (!o_sda_oe)[*2];
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("command acked while busy");
  property p_incr;
    @(posedge i_clk) disable iff (i_reset)
    load_tx |=> ptr_reg == 8'($past(ptr_reg) + 8'h01) && shift_reg == $past(rdata);
  endproperty
  a_incr: assert property (p_incr) else $error("read location not advanced");
  property p_ptr_wrap;
    @(posedge i_clk) disable iff (i_reset)
    (load_tx && ptr_reg == 8'hff) |=> ptr_reg == 8'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("location did not wrap");
endmodule : eeac_top

//--- hw/eeac_params.svh
// Constants for the serial memory access block
`ifndef EEAC_PARAMS_SVH
`define EEAC_PARAMS_SVH
`define EEAC_CLK_HZ 100000000
`define EEAC_TWR_MS 10
`define EEAC_TWR_MAX_MS 50
`define EEAC_DEV_ADDR 7'h48
`define EEAC_CMD_MEM 8'h17
`define EEAC_ACK_SLOT 4'h8
`define EEAC_PAGE_BYTES 8
`define EEAC_MEM_DEPTH 256
`endif

//--- hw/eeac_pkg.sv
// Types shared by the serial memory access block
package eeac_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_LOC, ST_WDATA, ST_RDATA} eeac_bus_e;
  typedef enum logic [1:0] {PG_IDLE, PG_COPY, PG_WAIT} eeac_pg_e;
  typedef struct packed {
    logic [2:0] idx;
    logic [7:0] data;
  } eeac_wbyte_s;
endpackage : eeac_pkg

//--- hw/eeac_mem.sv
// Byte memory with one write port and a registered read port
module eeac_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem_reg[i_raddr];
  end
endmodule : eeac_mem

//--- tb/eeac_master_model.sv
// Two-wire bus master model that drives the serial memory block
module eeac_master_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe,
  output logic o_res_valid,
  output logic [8:0] o_res
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles with the clock high and data released to its pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_res_valid = 1'b0;
    o_res = 9'h000;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask : hold
  // Long low phase so the device's late answer settles before the clock rises
  task automatic bit_cell(input logic b, output logic r);
    o_sda_oe <= ~b;
    hold(4);
    o_scl <= 1'b1;
    hold(3);
    r = i_sda;
    o_scl <= 1'b0;
    hold(1);
  endtask : bit_cell
  task automatic start;
    o_sda_oe <= 1'b0;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    o_sda_oe <= 1'b1;
    hold(4);
    o_scl <= 1'b0;
    hold(1);
  endtask : start
  task automatic stop;
    o_sda_oe <= 1'b1;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    o_sda_oe <= 1'b0;
    hold(8);
  endtask : stop
  task automatic post(input logic [8:0] v);
    o_res <= v;
    o_res_valid <= 1'b1;
    hold(1);
    o_res_valid <= 1'b0;
  endtask : post
  task automatic send_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(d[i], r);
    bit_cell(1'b1, r);
    post({~r, 8'h00});
  endtask : send_byte
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(1'b1, d[i]);
    bit_cell(last, r);
    post({1'b0, d});
  endtask : recv_byte
endmodule : eeac_master_model

//--- tb/eeac_top_tb.sv
// Self-checking bench for the serial memory block
module eeac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h3b;
  localparam int unsigned PROG = 400;
  logic i_clk;
  logic i_reset;
  logic scl, m_oe, res_valid, sda_out, sda_oe, busy;
  logic [8:0] res;
  wire sda;
  logic [7:0] model [256];
  logic [8:0] expq [$];
  int miscompares = 0;
  int n_checks = 0;
  int busy_run = 0;
  int last_run = 0;
  assign sda = ~(m_oe | (sda_oe & ~sda_out));
  eeac_top #(.DEV_ADDR(DEV), .PROG_CYCLES(PROG)) DUT (.i_clk(i_clk), .i_reset(i_reset),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
  eeac_master_model M (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe),
    .o_res_valid(res_valid), .o_res(res));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic fail(input string msg);
    miscompares++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk) begin
    if (res_valid === 1'b1) begin
      n_checks++;
      if (expq.size() == 0) fail("result without note");
      else if (res !== expq.pop_front()) fail("bus result");
    end
    if (busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      last_run = busy_run;
      busy_run = 0;
    end
  end
  task automatic wb(input logic [7:0] d, input logic ack);
    expq.push_back({ack, 8'h00});
    M.send_byte(d);
  endtask : wb
  task automatic check_busy(input logic e);
    n_checks++;
    if (busy !== e) fail("busy level");
  endtask : check_busy
  task automatic open_mem(input logic [7:0] loc);
    M.start();
    wb({DEV, 1'b0}, 1'b1);
    wb(8'h17, 1'b1);
    wb(loc, 1'b1);
  endtask : open_mem
  task automatic wait_prog;
    int n;
    n = 0;
    // A stale length from an earlier write must not pass a missing one
    last_run = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (2) @(posedge i_clk);
    n_checks++;
    if (n >= 5000) fail("programming never ended");
    if (last_run < PROG || last_run > PROG + 20) fail("programming time");
  endtask : wait_prog
  task automatic mem_write(input logic [7:0] loc, input logic [7:0] d[$], input logic commit);
    open_mem(loc);
    foreach (d[k]) wb(d[k], 1'b1);
    check_busy(1'b0);
    if (commit) begin
      M.stop();
      foreach (d[k]) model[{loc[7:3], loc[2:0] + k[2:0]}] = d[k];
      check_busy(1'b1);
    end else begin
      // A START in place of the closing STOP discards the page
      M.start();
      wb({DEV, 1'b0}, 1'b1);
      M.stop();
      check_busy(1'b0);
    end
  endtask : mem_write
  task automatic mem_read(input logic [7:0] loc, input int n);
    open_mem(loc);
    M.start();
    wb({DEV, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      expq.push_back({1'b0, model[8'(loc + k)]});
      M.recv_byte(k == n - 1);
    end
    M.stop();
  endtask : mem_read
  initial begin
    logic [7:0] rnd [$];
    i_reset = 1'b1;
    void'($urandom(34));
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (6) @(posedge i_clk);
    mem_write(8'h00, {8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99},
      1'b1);
    M.start();
    wb({DEV, 1'b0}, 1'b1);
    wb(8'h17, 1'b0);
    M.stop();
    wait_prog();
    mem_read(8'h00, 8);
    for (int k = 0; k < 8; k++) rnd.push_back(8'($urandom));
    mem_write(8'hf8, rnd, 1'b1);
    wait_prog();
    mem_write(8'hfe, {8'h5a, 8'ha5}, 1'b0);
    mem_read(8'hfc, 6);
    M.start();
    wb({~DEV, 1'b0}, 1'b0);
    M.start();
    wb({DEV, 1'b0}, 1'b1);
    wb(8'hac, 1'b0);
    M.stop();
    repeat (4) @(posedge i_clk);
    n_checks++;
    if (expq.size() != 0) fail("bus results missing");
    report_and_stop();
  end
  // Whole run is near 50 us; ten times that means a hang
  initial begin
    #500us;
    fail("watchdog expired");
    report_and_stop();
  end
endmodule : eeac_top_tb
